// ==== logic/ipl_controller.sv ====
// Priority manager of a vectored interrupt controller with AXI4-Lite regs.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ipl_controller
    import ipl_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write address and data.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Peripheral request pins.
    input wire logic [NumSrc-1:NumSoft] periphReq,
    // Processor request and summary interrupt.
    output logic cpuIrq,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [NumSrc-1:NumSoft] reqMeta;
        logic [NumSrc-1:NumSoft] reqSync;
        logic [PriW-1:0] curPri;
        logic [NumPri*PriW-1:0] stack;
        logic [StackW-1:0] depth;
        logic [NumSoft-1:0] softPend;
        logic [NumSrc*PriW-1:0] priSel;
        logic [NumSrc-1:0] enable;
        logic [NumEv-1:0] stat;
        logic [NumEv-1:0] statEn;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic cpuIrq;
    } ipl_state_t;

    ipl_state_t st_ff;
    ipl_state_t nxt_st;

    logic found;
    logic [VecW-1:0] winVec;
    logic [PriW-1:0] winPri;
    logic [NumSrc-1:0] allReq;

    // Soft requests take the low vectors, peripherals the rest.
    assign allReq = {st_ff.reqSync, st_ff.softPend} & st_ff.enable;

    ipl_arbiter uArb (
        .req(allReq),
        .current_priority_field(st_ff.priSel),
        .found(found),
        .winVec(winVec),
        .winPri(winPri)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake outputs.
    assign awready = !st_ff.awHeld && !st_ff.bValid;
    assign wready = !st_ff.wHeld && !st_ff.bValid;
    // Reads wait while a write executes, so the saved-priority stack never
    // sees a pop and a push in the same cycle.
    assign arready = !st_ff.rValid && !(st_ff.awHeld && st_ff.wHeld);
    assign bvalid = st_ff.bValid;
    assign bresp = st_ff.bResp;
    assign rvalid = st_ff.rValid;
    assign rdata = st_ff.rData;
    assign rresp = st_ff.rResp;
    assign cpuIrq = st_ff.cpuIrq;
    assign irq = |(st_ff.stat & st_ff.statEn);

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [NumEv-1:0] ev;
        logic [NumEv-1:0] clr;
        logic [PriW-1:0] popVal;
        nxt_st = st_ff;
        wd = '0;
        rd = '0;
        rr = RespOkay;
        ev = '0;
        clr = '0;
        popVal = '0;
        // Pin synchronisers.
        nxt_st.reqMeta = periphReq;
        nxt_st.reqSync = st_ff.reqMeta;
        // Capture address and data in either order.
        if (awvalid && awready) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = wdata;
            nxt_st.wStrb = wstrb;
        end
        if (st_ff.bValid && bready) begin
            nxt_st.bValid = 1'b0;
        end
        if (st_ff.rValid && rready) begin
            nxt_st.rValid = 1'b0;
        end
        // Register write once both halves are held.
        if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
            wd = st_ff.wData;
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld = 1'b0;
            nxt_st.bValid = 1'b1;
            nxt_st.bResp = RespOkay;
            unique case (st_ff.awAddr)
                OffCurPri: begin
                    if (st_ff.wStrb[0]) begin
                        nxt_st.curPri = wd[PriW-1:0];
                    end
                end
                OffEoi: begin
                    // Any store pops; an empty stack restores zero.
                    if (st_ff.depth != '0) begin
                        popVal = st_ff.stack[(32'(st_ff.depth) - 1) * PriW
                            +: PriW];
                        nxt_st.depth = st_ff.depth - 1'b1;
                    end else begin
                        ev[EvUnderflow] = 1'b1;
                    end
                    nxt_st.curPri = popVal;
                    ev[EvEoi] = 1'b1;
                end
                OffSoft: begin
                    for (int i = 0; i < NumSoft; i++) begin
                        if (wd[SoftClrLsb + i]) begin
                            nxt_st.softPend[i] = 1'b0;
                        end
                    end
                    for (int i = 0; i < NumSoft; i++) begin
                        if (wd[SoftSetLsb + i]) begin
                            nxt_st.softPend[i] = 1'b1;
                        end
                    end
                end
                OffPriSel0: begin
                    nxt_st.priSel[31:0] = wd;
                end
                OffPriSel1: begin
                    nxt_st.priSel[63:32] = wd;
                end
                OffEnable: begin
                    nxt_st.enable = wd[NumSrc-1:0];
                end
                OffIrqClr: begin
                    clr = wd[NumEv-1:0];
                end
                OffIrqEn: begin
                    nxt_st.statEn = wd[NumEv-1:0];
                end
                OffCtrl, OffAck, OffIrqStat, OffStackDepth: begin
                end
                default: begin
                    nxt_st.bResp = RespSlvErr;
                end
            endcase
        end
        // Register read; an acknowledge read takes the winner.
        if (arvalid && arready) begin
            unique case (araddr)
                OffCtrl: rd = 32'(NumPri);
                OffCurPri: rd = 32'(st_ff.curPri);
                OffAck: begin
                    rd[VecW-1:0] = winVec;
                    rd[AckValidBit] = found;
                    // Push current priority, even if nothing is pending.
                    if (st_ff.depth < StackW'(NumPri)) begin
                        nxt_st.stack[32'(st_ff.depth) * PriW +: PriW] =
                            st_ff.curPri;
                        nxt_st.depth = st_ff.depth + 1'b1;
                    end else begin
                        ev[EvOverflow] = 1'b1;
                    end
                    if (found) begin
                        nxt_st.curPri = winPri;
                    end
                    ev[EvAck] = 1'b1;
                end
                OffSoft: begin
                    rd[SoftClrLsb +: NumSoft] = st_ff.softPend;
                end
                OffPriSel0: rd = st_ff.priSel[31:0];
                OffPriSel1: rd = st_ff.priSel[63:32];
                OffEnable: rd = 32'(st_ff.enable);
                OffIrqStat: rd = 32'(st_ff.stat);
                OffIrqEn: rd = 32'(st_ff.statEn);
                OffStackDepth: rd = 32'(st_ff.depth);
                OffEoi, OffIrqClr: rd = '0;
                default: rr = RespSlvErr;
            endcase
            nxt_st.rValid = 1'b1;
            nxt_st.rData = rd;
            nxt_st.rResp = rr;
        end
        // Request only when the winner beats the current priority.
        nxt_st.cpuIrq = found && (winPri > st_ff.curPri);
        // Sticky status, set wins over clear.
        nxt_st.stat = (st_ff.stat & ~clr) | ev;
        if (!rst_b) begin
            nxt_st = '0;
            nxt_st.enable = EnableReset;
        end
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end
endmodule // ipl_controller

// ==== logic/ipl_pkg.sv ====
// Package with register map, field layouts and sizes of the priority block.
package ipl_pkg;
    localparam int NumSrc = 16;
    localparam int NumSoft = 8;
    localparam int PriW = 4;
    localparam int NumPri = 16;
    localparam int VecW = 4;
    localparam int StackW = 5;
    // Register byte offsets.
    localparam logic [7:0] OffCtrl = 8'h00;
    localparam logic [7:0] OffAck = 8'h10;
    localparam logic [7:0] OffEoi = 8'h18;
    localparam logic [7:0] OffCurPri = 8'h08;
    localparam logic [7:0] OffSoft = 8'h20;
    localparam logic [7:0] OffPriSel0 = 8'h40;
    localparam logic [7:0] OffPriSel1 = 8'h44;
    localparam logic [7:0] OffEnable = 8'h60;
    localparam logic [7:0] OffIrqStat = 8'h70;
    localparam logic [7:0] OffIrqClr = 8'h74;
    localparam logic [7:0] OffIrqEn = 8'h78;
    localparam logic [7:0] OffStackDepth = 8'h7c;
    // Soft request register: set bits in 7:0, clear bits in 15:8.
    localparam int SoftSetLsb = 0;
    localparam int SoftClrLsb = 8;
    // Acknowledge register: vector in 3:0, valid in bit 31.
    localparam int AckValidBit = 31;
    // Status event bits.
    localparam int EvAck = 0;
    localparam int EvEoi = 1;
    localparam int EvOverflow = 2;
    localparam int EvUnderflow = 3;
    localparam int NumEv = 4;
    localparam logic [1:0] RespOkay = 2'h0;
    localparam logic [1:0] RespSlvErr = 2'h2;
    localparam logic [NumSrc-1:0] EnableReset = 16'h0000;
endpackage

// ==== logic/ipl_arbiter.sv ====
// Priority arbiter that picks the highest-priority source, lowest vector on a tie.
`timescale 1ns/1ps
module ipl_arbiter
    import ipl_pkg::*;
(
    // Requests and priorities.
    input wire logic [NumSrc-1:0] req,
    input wire logic [NumSrc*PriW-1:0] current_priority_field,
    // Winner.
    output logic found,
    output logic [VecW-1:0] winVec,
    output logic [PriW-1:0] winPri
);
    // Scan from the top vector down so the lowest vector wins ties.
    always_comb begin
        found = 1'b0;
        winVec = '0;
        winPri = '0;
        for (int i = NumSrc - 1; i >= 0; i--) begin
            if (req[i] && current_priority_field[i*PriW +: PriW] != '0 &&
                (!found || current_priority_field[i*PriW +: PriW] >= winPri)) begin
                found = 1'b1;
                winVec = VecW'(i);
                winPri = current_priority_field[i*PriW +: PriW];
            end
        end
    end
endmodule // ipl_arbiter

// ==== dv/ipl_core_model.sv ====
// Processor core model that recognises the controller's request.
`timescale 1ns/1ps
module ipl_core_model (
    // Clock, request and recognition switch.
    input wire logic clk,
    input wire logic cpuIrq,
    input wire logic recogOn,
    // Request as the core recognises it.
    output logic irqSeen
);
    // Requests are only recognised while recognition is on.
    always_ff @(posedge clk) begin
        irqSeen <= cpuIrq & recogOn;
    end
endmodule // ipl_core_model

// ==== dv/ipl_controller_properties.sv ====
// Checker of bus handshakes and register answers of the controller.
`timescale 1ns/1ps
module ipl_controller_chk
    import ipl_pkg::*;
(
    input wire logic clk, rst_b, awvalid, awready, wvalid, wready,
    input wire logic bvalid, bready, arvalid, arready, rvalid, rready,
    input wire logic [1:0] bresp, rresp,
    input wire logic [7:0] araddr,
    input wire logic [31:0] rdata
);
    // All checks share the one clock and its reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A write answer that waits for ready keeps its response code.
    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp moved");
    // A read answer that waits for ready keeps its data.
    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata moved");
    no_read_busy_a: assert property (
        rvalid |-> !arready)
        else $error("arready busy");
    no_write_busy_a: assert property (
        bvalid |-> !awready && !wready)
        else $error("wready busy");
    read_answer_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("no rvalid");
    write_answer_a: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("no bvalid");
    // Nothing answers at the gap where stack entries would sit.
    stack_hidden_a: assert property (
        arvalid && arready && araddr == 8'h04 |=> rresp == RespSlvErr)
        else $error("no slverr");
    level_count_a: assert property (
        arvalid && arready && araddr == OffCtrl |=> rdata == 32'h10)
        else $error("bad count");
endmodule // ipl_controller_chk
bind ipl_controller ipl_controller_chk chk (.*);

// ==== dv/ipl_controller_test.sv ====
// Self-checking bench of the priority controller with a behavioural model.
`timescale 1ns/1ps
module ipl_controller_test;
    import ipl_pkg::*;
    logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, recogOn = 1;
    logic awready, wready, bvalid, arready, rvalid, cpuIrq, irq, irqSeen;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic [NumSrc-1:NumSoft] periphReq = 0;
    logic [63:0] pv;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 32'h6ccf, cur;
    int current_priority_field[16], stk[$];
    logic [15:0] pend, en;
    ipl_controller uut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .periphReq(periphReq), .cpuIrq(cpuIrq), .irq(irq));
    ipl_core_model core (.clk(clk), .cpuIrq(cpuIrq), .recogOn(recogOn),
        .irqSeen(irqSeen));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard.
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Prints counts and verdict, then ends the run.
    task wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Bus cycles; each holds valid until its own ready is sampled.
    // Ready for the answer is raised only once the answer stands, so every
    // answer waits one cycle and must hold still meanwhile.
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic pa;
        logic pw;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa | pw) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Model winner: highest enabled pending priority; scanning upwards and
    // taking only a strictly higher one leaves ties with the lowest vector.
    function int win();
        win = -1;
        for (int v = 0; v < NumSrc; v++) begin
            if (pend[v] && en[v] && current_priority_field[v] > 0 &&
                (win < 0 || current_priority_field[v] > current_priority_field[win])) begin
                win = v;
            end
        end
    endfunction
    // Takes, clears and ends interrupts like nested service routines.
    task serve();
        int w;
        logic hit;
        forever begin
            w = win();
            hit = w >= 0 && current_priority_field[w] > cur;
            repeat (4) @(posedge clk);
            chk("cpuIrq", irqSeen, hit);
            if (hit) begin
                rd(OffAck);
                chk("ack", {d[31], d[3:0]}, {1'b1, w[3:0]});
                stk.push_back(cur);
                cur = current_priority_field[w];
                pend[w] = 1'b0;
                if (w < NumSoft) wr(OffSoft, 32'h1 << (SoftClrLsb + w));
                else periphReq[w] <= 1'b0;
            end else if (stk.size() > 0) begin
                wr(OffEoi, 32'h0);
                cur = stk.pop_back();
            end else begin
                break;
            end
            rd(OffCurPri);
            chk("curPri", d, cur);
            rd(OffStackDepth);
            chk("depth", d, stk.size());
        end
        $display("serve pass done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(OffCtrl);
        chk("levels", d, NumPri);
        rd(OffEnable);
        chk("enable", d, 32'(EnableReset));
        rd(8'h04);
        chk("hidden", r, RespSlvErr);
        wr(8'h04, 32'h0);
        chk("hiddenWr", r, RespSlvErr);
        $display("reset test done");
        pv = {$random(seed), $random(seed)};
        pv[3:0] = 4'hf;
        for (int v = 0; v < NumSrc; v++) begin
            current_priority_field[v] = pv[4*v +: 4];
        end
        en = 16'($random(seed));
        en[0] = 1'b1;
        pend = 16'($random(seed));
        pend[0] = 1'b1;
        cur = $random(seed) & 7;
        wr(OffPriSel0, pv[31:0]);
        wr(OffPriSel1, pv[63:32]);
        rd(OffPriSel1);
        chk("priSel1", d, pv[63:32]);
        wr(OffEnable, {16'h0, en});
        wr(OffIrqEn, 32'h1 << EvAck);
        chk("bresp", r, RespOkay);
        recogOn <= 1'b0;
        wr(OffCurPri, cur);
        recogOn <= 1'b1;
        wr(OffSoft, {24'h0, pend[7:0]});
        periphReq <= pend[15:8];
        rd(OffSoft);
        chk("softPend", d[15:8], pend[7:0]);
        serve();
        chk("irq", irq, 1'b1);
        wr(OffIrqClr, 32'hf);
        chk("irq", irq, 1'b0);
        // Priority is lowered only with the stack empty, outside a routine.
        recogOn <= 1'b0;
        cur = 0;
        wr(OffCurPri, 32'h0);
        recogOn <= 1'b1;
        serve();
        // End of interrupt on an empty stack restores zero and flags it.
        wr(OffIrqClr, 32'hf);
        wr(OffEoi, 32'h0);
        rd(OffIrqStat);
        chk("underflow", d, 32'(1 << EvEoi | 1 << EvUnderflow));
        rd(OffCurPri);
        chk("popZero", d, 32'h0);
        $display("stack end test done");
        wrap_up();
    end
endmodule // ipl_controller_test
